// >>> src/tcw_pkg.sv
// Shared constants of the timer compare and waveform unit.
package tcw_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets on the Wishbone bus.
   // ----------------------------------------------------------------
   localparam logic [7:0] TCW_ADDR_CTRL  = 8'h00;
   localparam logic [7:0] TCW_ADDR_COUNT = 8'h04;
   localparam logic [7:0] TCW_ADDR_CMPA  = 8'h08;
   localparam logic [7:0] TCW_ADDR_FLAGS = 8'h0c;
   localparam logic [7:0] TCW_ADDR_FORCE = 8'h10;
   localparam logic [7:0] TCW_ADDR_PORT  = 8'h14;

   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int TCW_CTRL_ACT_LSB  = 0;
   localparam int TCW_CTRL_MODE_LSB = 2;
   localparam int TCW_CTRL_CLK_LSB  = 5;
   localparam int TCW_FLAG_OVF_BIT  = 0;
   localparam int TCW_FLAG_CMP_BIT  = 1;
   localparam int TCW_FLAG_WAVE_BIT = 2;
   localparam int TCW_FORCE_BIT     = 0;
   localparam int TCW_PORT_OUT_BIT  = 0;
   localparam int TCW_PORT_DIR_BIT  = 1;

   // ----------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------
   localparam logic [7:0] TCW_CTRL_RST  = 8'h00;
   localparam logic [7:0] TCW_COUNT_RST = 8'h00;
   localparam logic [7:0] TCW_CMPA_RST  = 8'h00;
   localparam logic [1:0] TCW_PORT_RST  = 2'h0;

   // ----------------------------------------------------------------
   // Waveform modes, output actions and count limits.
   // ----------------------------------------------------------------
   localparam logic [2:0] TCW_MODE_NORMAL   = 3'h0;
   localparam logic [2:0] TCW_MODE_CLEAR    = 3'h2;
   localparam logic [2:0] TCW_MODE_FAST_MAX = 3'h3;
   localparam logic [2:0] TCW_MODE_FAST_CMP = 3'h7;
   localparam logic [1:0] TCW_ACT_OFF       = 2'h0;
   localparam logic [1:0] TCW_ACT_TOGGLE    = 2'h1;
   localparam logic [1:0] TCW_ACT_CLEAR     = 2'h2;
   localparam logic [1:0] TCW_ACT_SET       = 2'h3;
   localparam logic [7:0] TCW_MAX           = 8'hff;
   localparam logic [7:0] TCW_BOTTOM        = 8'h00;

   // ----------------------------------------------------------------
   // Prescaler: last value of the divider count for each clock select.
   // ----------------------------------------------------------------
   localparam logic [2:0] TCW_CLK_STOP   = 3'h0;
   localparam logic [9:0] TCW_DIV1_LAST    = 10'h000;
   localparam logic [9:0] TCW_DIV8_LAST    = 10'h007;
   localparam logic [9:0] TCW_DIV32_LAST   = 10'h01f;
   localparam logic [9:0] TCW_DIV64_LAST   = 10'h03f;
   localparam logic [9:0] TCW_DIV128_LAST  = 10'h07f;
   localparam logic [9:0] TCW_DIV256_LAST  = 10'h0ff;
   localparam logic [9:0] TCW_DIV1024_LAST = 10'h3ff;

endpackage

// >>> src/tcw_timer.sv
// Timer compare unit with waveform modes and port pin override.
//
// How it works
// - A nonzero output action selects the waveform register onto the pin.
// - Pin direction bit alone decides whether the pin is driven.
// - Override choice looks only at the output action, never the mode.
// - Waveform register can be preset while the pin is still an input.
// - Output action zero leaves the waveform register untouched on match.
// - A new output action applies from the next compare match onward.
// - In non-PWM modes the force strobe applies the action at once.
// - Count sequence depends on mode only; action only shapes the output.
// - Mode 0 always counts up and wraps from 0xFF to 0x00.
// - Normal mode raises overflow as the count becomes zero.
// - Hardware only sets the overflow flag; software clears it.
// - Mode 2 clears the counter when it equals compare A.
// - In clear mode the compare A flag rises at each top.
// - Compare A is unbuffered in clear mode; a low write misses.
// - Clear mode with action 1 toggles output A on each match.
// - Compare zero, no prescale, toggle gives half the clock rate.
// - Clear mode raises overflow when passing from maximum to 0x00.
// - Modes 3 and 7 count up to 0xFF or compare A, then restart.
// - Fast PWM clears the counter after top and raises overflow there.
// - Fast PWM action 2 clears on match, sets at bottom; 3 inverts.
// - Fast PWM gives a spike at compare zero, constant level at max.
// - Fast PWM action 1 in mode 7 toggles on each compare match.
// - Compare flag rises one timer tick after the count equals compare.
// - In PWM modes compare writes are buffered until the top.
// - A counter write blocks any compare match on the next tick.
`timescale 1ns/1ps

module tcw_timer
   import tcw_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave.
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Port pin.
   output logic             pin_o,
   output logic             pin_oe_n_o,
   // Internal state for observation.
   output logic             waveform_out_a_o,
   output logic             overflow_flag_o,
   output logic             compare_flag_a_o
);

   // ----------------------------------------------------------------
   // Declarations.
   // ----------------------------------------------------------------
   logic [7:0]  ctrl_reg, count_value_reg, compare_buf_reg;
   logic [7:0]  compare_value_a_reg, top_value;
   logic        block_reg, port_out_reg, pin_direction_bit_reg;
   logic [9:0]  pre_count_reg, div_last;
   logic [1:0]  output_action_select_a;
   logic [2:0]  waveform_mode_select, clk_sel;
   logic        is_fast, is_nonpwm, at_top, match, tick;
   logic        bus_take, bus_wr, wr_ctrl, wr_count, wr_cmpa;
   logic        wr_flags, wr_force, wr_port;
   logic        ovf_set, cmp_set, override;
   logic [31:0] rd_next;
   // ----------------------------------------------------------------
   // Control decode.
   // ----------------------------------------------------------------
   // Mode and action fields are split out of the control register.
   assign output_action_select_a = ctrl_reg[TCW_CTRL_ACT_LSB +: 2];
   assign waveform_mode_select   = ctrl_reg[TCW_CTRL_MODE_LSB +: 3];
   assign clk_sel                = ctrl_reg[TCW_CTRL_CLK_LSB +: 3];
   assign is_fast   = (waveform_mode_select == TCW_MODE_FAST_MAX) ||
                      (waveform_mode_select == TCW_MODE_FAST_CMP);
   assign is_nonpwm = (waveform_mode_select == TCW_MODE_NORMAL) ||
                      (waveform_mode_select == TCW_MODE_CLEAR);
   // Top of the count and the comparator; a pending block masks a match.
   assign top_value = (waveform_mode_select == TCW_MODE_FAST_CMP) ?
                      compare_value_a_reg : TCW_MAX;
   assign at_top    = is_fast && (count_value_reg == top_value);
   assign match     = (count_value_reg == compare_value_a_reg) &&
                      !block_reg;
   // ----------------------------------------------------------------
   // Bus decode.
   // ----------------------------------------------------------------
   // A request is taken once; ack follows on the next edge.
   assign bus_take = cyc_i && stb_i && !ack_o;
   assign bus_wr   = bus_take && we_i && sel_i[0];
   assign wr_ctrl  = bus_wr && (adr_i == TCW_ADDR_CTRL);
   assign wr_count = bus_wr && (adr_i == TCW_ADDR_COUNT);
   assign wr_cmpa  = bus_wr && (adr_i == TCW_ADDR_CMPA);
   assign wr_flags = bus_wr && (adr_i == TCW_ADDR_FLAGS);
   assign wr_force = bus_wr && (adr_i == TCW_ADDR_FORCE) &&
                     dat_i[TCW_FORCE_BIT];
   assign wr_port  = bus_wr && (adr_i == TCW_ADDR_PORT);
   // Read data selection; unmapped offsets read as zero.
   always_comb begin
      rd_next = 32'h0000_0000;
      case (adr_i)
         TCW_ADDR_CTRL:  rd_next[7:0] = ctrl_reg;
         TCW_ADDR_COUNT: rd_next[7:0] = count_value_reg;
         TCW_ADDR_CMPA:  rd_next[7:0] = compare_buf_reg;
         TCW_ADDR_FLAGS: begin
            rd_next[TCW_FLAG_OVF_BIT]  = overflow_flag_o;
            rd_next[TCW_FLAG_CMP_BIT]  = compare_flag_a_o;
            rd_next[TCW_FLAG_WAVE_BIT] = waveform_out_a_o;
         end
         TCW_ADDR_PORT: begin
            rd_next[TCW_PORT_OUT_BIT] = port_out_reg;
            rd_next[TCW_PORT_DIR_BIT] = pin_direction_bit_reg;
         end
         default: rd_next = 32'h0000_0000;
      endcase
   end
   // Ack pulses one cycle per request; read data is captured with it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_take;
         if (bus_take && !we_i) begin
            dat_o <= rd_next;
         end
      end
   end
   // Software-held control and port registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg              <= TCW_CTRL_RST;
         port_out_reg          <= TCW_PORT_RST[TCW_PORT_OUT_BIT];
         pin_direction_bit_reg <= TCW_PORT_RST[TCW_PORT_DIR_BIT];
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= dat_i[7:0];
         end
         if (wr_port) begin
            port_out_reg          <= dat_i[TCW_PORT_OUT_BIT];
            pin_direction_bit_reg <= dat_i[TCW_PORT_DIR_BIT];
         end
      end
   end
   // ----------------------------------------------------------------
   // Prescaler.
   // ----------------------------------------------------------------
   // Divider end value for the selected clock source.
   always_comb begin
      case (clk_sel)
         3'h1:    div_last = TCW_DIV1_LAST;
         3'h2:    div_last = TCW_DIV8_LAST;
         3'h3:    div_last = TCW_DIV32_LAST;
         3'h4:    div_last = TCW_DIV64_LAST;
         3'h5:    div_last = TCW_DIV128_LAST;
         3'h6:    div_last = TCW_DIV256_LAST;
         3'h7:    div_last = TCW_DIV1024_LAST;
         default: div_last = TCW_DIV1_LAST;
      endcase
   end
   // Tick enable; a stopped clock select holds the divider at zero.
   assign tick = (clk_sel != TCW_CLK_STOP) &&
                 (pre_count_reg == div_last);
   always_ff @(posedge clk_i) begin
      if (rst_i || (clk_sel == TCW_CLK_STOP)) begin
         pre_count_reg <= 10'h000;
      end else if (pre_count_reg >= div_last) begin
         pre_count_reg <= 10'h000;
      end else begin
         pre_count_reg <= pre_count_reg + 10'h001;
      end
   end
   // ----------------------------------------------------------------
   // Counter.
   // ----------------------------------------------------------------
   // A bus write wins over counting; the next step depends on mode only.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_value_reg <= TCW_COUNT_RST;
      end else if (wr_count) begin
         count_value_reg <= dat_i[7:0];
      end else if (tick) begin
         if ((waveform_mode_select == TCW_MODE_CLEAR) && match) begin
            count_value_reg <= TCW_BOTTOM;
         end else if (at_top) begin
            count_value_reg <= TCW_BOTTOM;
         end else begin
            // Plain increment wraps from maximum to zero.
            count_value_reg <= count_value_reg + 8'h01;
         end
      end
   end
   // A counter write arms the block until the next tick, even if stopped.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         block_reg <= 1'b0;
      end else if (wr_count) begin
         block_reg <= 1'b1;
      end else if (tick) begin
         block_reg <= 1'b0;
      end
   end
   // Compare A: direct in non-PWM modes, buffered until top in PWM.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_buf_reg     <= TCW_CMPA_RST;
         compare_value_a_reg <= TCW_CMPA_RST;
      end else begin
         if (wr_cmpa) begin
            compare_buf_reg <= dat_i[7:0];
         end
         if (wr_cmpa && !is_fast) begin
            compare_value_a_reg <= dat_i[7:0];
         end else if (tick && !wr_count && at_top) begin
            compare_value_a_reg <= compare_buf_reg;
         end
      end
   end
   // ----------------------------------------------------------------
   // Flags.
   // ----------------------------------------------------------------
   // Overflow: passing maximum in non-PWM, reaching top in fast PWM.
   assign ovf_set = tick && !wr_count &&
                    (is_fast ? at_top
                             : (count_value_reg == TCW_MAX));
   assign cmp_set = tick && !wr_count && match;
   // Flags are cleared by writing one; a same-cycle set wins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overflow_flag_o  <= 1'b0;
         compare_flag_a_o <= 1'b0;
      end else begin
         if (ovf_set) begin
            overflow_flag_o <= 1'b1;
         end else if (wr_flags && dat_i[TCW_FLAG_OVF_BIT]) begin
            overflow_flag_o <= 1'b0;
         end
         if (cmp_set) begin
            compare_flag_a_o <= 1'b1;
         end else if (wr_flags && dat_i[TCW_FLAG_CMP_BIT]) begin
            compare_flag_a_o <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // Waveform output register.
   // ----------------------------------------------------------------
   // The action field is read at the event itself, so a rewrite only
   // shows from the next match; the force strobe is the exception.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         waveform_out_a_o <= 1'b0;
      end else if (is_nonpwm &&
                   (wr_force || (tick && !wr_count && match))) begin
         case (output_action_select_a)
            TCW_ACT_TOGGLE: waveform_out_a_o <= !waveform_out_a_o;
            TCW_ACT_CLEAR:  waveform_out_a_o <= 1'b0;
            TCW_ACT_SET:    waveform_out_a_o <= 1'b1;
            default:        waveform_out_a_o <= waveform_out_a_o;
         endcase
      end else if (tick && !wr_count && is_fast) begin
         // For actions 2 and 3 the top event wins over a match when compare equals top; toggle acts on the match in mode 7 only.
         case (output_action_select_a)
            TCW_ACT_TOGGLE: begin
               if ((waveform_mode_select == TCW_MODE_FAST_CMP) && match) begin
                  waveform_out_a_o <= !waveform_out_a_o;
               end
            end
            TCW_ACT_CLEAR: begin
               if (at_top) begin
                  waveform_out_a_o <= 1'b1;
               end else if (match) begin
                  waveform_out_a_o <= 1'b0;
               end
            end
            TCW_ACT_SET: begin
               if (at_top) begin
                  waveform_out_a_o <= 1'b0;
               end else if (match) begin
                  waveform_out_a_o <= 1'b1;
               end
            end
            default: waveform_out_a_o <= waveform_out_a_o;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Pin override.
   // ----------------------------------------------------------------
   // Override depends on the action field alone; direction stays with
   // the direction bit, so a preset level appears when it is enabled.
   assign override = (output_action_select_a != TCW_ACT_OFF);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o      <= 1'b0;
         pin_oe_n_o <= 1'b1;
      end else begin
         pin_o      <= override ? waveform_out_a_o : port_out_reg;
         pin_oe_n_o <= !pin_direction_bit_reg;
      end
   end
   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   // Pin level follows the selected source one cycle later.
   property p_pin_source;
      @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> pin_o == ($past(override) ? $past(waveform_out_a_o)
                                               : $past(port_out_reg));
   endproperty
   a_pin_source: assert property (p_pin_source)
      else $error("pin does not follow the selected source");
   // Pin enable tracks the direction bit only.
   property p_pin_dir;
      @(posedge clk_i) disable iff (rst_i)
      wr_port ##1 1'b1 |=> pin_oe_n_o == !$past(dat_i[TCW_PORT_DIR_BIT], 2);
   endproperty
   a_pin_dir: assert property (p_pin_dir)
      else $error("pin enable does not follow direction bit");
   // Action zero keeps the waveform register steady.
   property p_act_off;
      @(posedge clk_i) disable iff (rst_i)
      (output_action_select_a == TCW_ACT_OFF) |=> $stable(waveform_out_a_o);
   endproperty
   a_act_off: assert property (p_act_off)
      else $error("waveform changed with action off");
   // Force with clear action in a non-PWM mode drives the register low.
   property p_force_clear;
      @(posedge clk_i) disable iff (rst_i)
      wr_force && is_nonpwm && (output_action_select_a == TCW_ACT_CLEAR)
      |=> !waveform_out_a_o;
   endproperty
   a_force_clear: assert property (p_force_clear)
      else $error("force strobe did not clear waveform");
   // Normal mode increments by one per tick.
   property p_normal_inc;
      @(posedge clk_i) disable iff (rst_i)
      tick && !wr_count && (waveform_mode_select == TCW_MODE_NORMAL)
      |=> count_value_reg == $past(count_value_reg) + 8'h01;
   endproperty
   a_normal_inc: assert property (p_normal_inc)
      else $error("normal mode did not increment");
   // Wrap from maximum raises overflow with the zero count.
   property p_wrap_ovf;
      @(posedge clk_i) disable iff (rst_i)
      tick && !wr_count && is_nonpwm && (count_value_reg == TCW_MAX)
      |=> overflow_flag_o && (count_value_reg == TCW_BOTTOM);
   endproperty
   a_wrap_ovf: assert property (p_wrap_ovf)
      else $error("overflow missing at wrap");
   // Overflow falls only by a software clear.
   property p_ovf_sticky;
      @(posedge clk_i) disable iff (rst_i)
      overflow_flag_o && !(wr_flags && dat_i[TCW_FLAG_OVF_BIT])
      |=> overflow_flag_o;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky)
      else $error("overflow cleared without software");
   // Clear mode match resets the counter and raises the compare flag.
   property p_clear_match;
      @(posedge clk_i) disable iff (rst_i)
      tick && !wr_count && match &&
      (waveform_mode_select == TCW_MODE_CLEAR)
      |=> (count_value_reg == TCW_BOTTOM) && compare_flag_a_o;
   endproperty
   a_clear_match: assert property (p_clear_match)
      else $error("clear mode match not handled");
   // Fast PWM at top goes to bottom with overflow.
   property p_fast_top;
      @(posedge clk_i) disable iff (rst_i)
      tick && !wr_count && at_top
      |=> (count_value_reg == TCW_BOTTOM) && overflow_flag_o;
   endproperty
   a_fast_top: assert property (p_fast_top)
      else $error("fast PWM top not handled");
   // In fast PWM the active compare changes only at a top tick.
   property p_buffered;
      @(posedge clk_i) disable iff (rst_i)
      $past(is_fast) && is_fast && $changed(compare_value_a_reg)
      |-> $past(tick && at_top);
   endproperty
   a_buffered: assert property (p_buffered)
      else $error("compare changed away from top");
   // A pending block keeps the compare flag from rising.
   property p_block;
      @(posedge clk_i) disable iff (rst_i)
      block_reg && tick && !compare_flag_a_o |=> !compare_flag_a_o;
   endproperty
   a_block: assert property (p_block)
      else $error("blocked compare match set flag");
endmodule // tcw_timer

// >>> verification/tcw_pin_model.sv
// Port pad model with a weak pull-down.
`timescale 1ns/1ps
module tcw_pin_model (
   // Pin as driven by the timer.
   input  wire logic pin_i,
   input  wire logic oe_n_i,
   // Level seen on the pad.
   output logic      pad_o
);
   // An undriven pad settles to the pull-down level.
   assign pad_o = oe_n_i ? 1'b0 : pin_i;
endmodule // tcw_pin_model

// >>> verification/tcw_timer_test.sv
// Self-checking bench for the timer compare and waveform unit.
`timescale 1ns/1ps
module tcw_timer_test import tcw_pkg::*; ;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [7:0] adr_i = 0, m_cnt, m_cmp, m_buf, m_ctrl;
   logic [3:0] sel_i = 4'hf;
   logic [31:0] dat_i = 0, dat_o;
   logic ack_o, pin_o, oe_n, wav, ovf, cfl, pad;
   logic m_ovf, m_cf, m_wave, m_pin, m_oe_n, m_blk, m_out, m_dir;
   int miscompares = 0, checks_done = 0, m_pre;
   // Prescale factor for each clock select; select zero stops the timer.
   int divs[8] = '{1, 1, 8, 32, 64, 128, 256, 1024};

   // ----------------------------------------------------------------
   // Design, pad and clock.
   // ----------------------------------------------------------------
   tcw_timer u_tcw_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_o(pin_o),
      .pin_oe_n_o(oe_n), .waveform_out_a_o(wav),
      .overflow_flag_o(ovf), .compare_flag_a_o(cfl));
   tcw_pin_model u_tcw_pin_model (.pin_i(pin_o), .oe_n_i(oe_n),
      .pad_o(pad));
   always #5 clk_i = !clk_i;

   // Reference model, stepped on every rising clock edge.
   always @(posedge clk_i) begin : model
      logic [1:0] act;
      logic [2:0] md;
      logic pwm, hit, at_top, wr, tk;
      act = m_ctrl[1:0];
      md = m_ctrl[4:2];
      pwm = md == TCW_MODE_FAST_MAX || md == TCW_MODE_FAST_CMP;
      at_top = m_cnt == (md == TCW_MODE_FAST_CMP ? m_cmp : TCW_MAX);
      hit = m_cnt == m_cmp && !m_blk;
      wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
      tk = m_ctrl[7:5] != 0 && m_pre == divs[m_ctrl[7:5]] - 1;
      if (rst_i) begin
         {m_cnt, m_cmp, m_buf, m_ctrl} = '0;
         {m_ovf, m_cf, m_wave, m_pin, m_blk, m_out, m_dir} = '0;
         m_oe_n = 1;
         m_pre = 0;
      end else begin
         m_pin = act != 0 ? m_wave : m_out;
         m_oe_n = !m_dir;
         if (wr && adr_i == TCW_ADDR_FLAGS) begin
            m_ovf = m_ovf && !dat_i[0];
            m_cf = m_cf && !dat_i[1];
         end
         if (tk && !(wr && adr_i == TCW_ADDR_COUNT)) begin
            m_blk = 0;
            if (hit) m_cf = 1;
            if (pwm ? at_top : m_cnt == TCW_MAX) m_ovf = 1;
            if (hit && act == 1 && (!pwm || md == TCW_MODE_FAST_CMP))
               m_wave = !m_wave;
            else if (hit && act[1]) m_wave = act[0];
            if (pwm && at_top && act[1]) m_wave = !act[0];
            if (pwm && at_top) m_cmp = m_buf;
            if (pwm ? at_top : md == TCW_MODE_CLEAR && hit) m_cnt = 0;
            else m_cnt = m_cnt + 8'h01;
         end
         m_pre = m_ctrl[7:5] == 0 || m_pre >= divs[m_ctrl[7:5]] - 1 ?
                 0 : m_pre + 1;
         if (wr) case (adr_i)
            TCW_ADDR_CTRL: m_ctrl = dat_i[7:0];
            TCW_ADDR_COUNT: {m_cnt, m_blk} = {dat_i[7:0], 1'b1};
            TCW_ADDR_CMPA: {m_buf, m_cmp} = {2{pwm ? m_cmp : dat_i[7:0]}};
            TCW_ADDR_PORT: {m_dir, m_out} = dat_i[1:0];
            TCW_ADDR_FORCE: if (!pwm && dat_i[0]) begin
               if (act == 1) m_wave = !m_wave;
               else if (act[1]) m_wave = act[0];
            end
            default: ;
         endcase
         if (wr && adr_i == TCW_ADDR_CMPA) m_buf = dat_i[7:0];
      end
   end

   // Compares the model with the design between clock edges.
   always @(negedge clk_i) if (!rst_i) begin
      check({m_wave, m_ovf, m_cf}, {wav, ovf, cfl});
      check({m_pin, m_oe_n, !m_oe_n & m_pin}, {pin_o, oe_n, pad});
   end

   task automatic check(input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t exp %h got %h", $time, exp, got);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // One classic Wishbone cycle, waiting a bounded time for ack.
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r);
      int n;
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      n = 0;
      do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin miscompares++; finish_test(); end
      r = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      wb(1, a, d, r);
   endtask

   // Stops the timer, loads compare and count, then runs a mode.
   task automatic run(input logic [2:0] md, input logic [1:0] act,
                      input logic [7:0] c, input logic [7:0] n0, input int k);
      wr(TCW_ADDR_CTRL, {3'h0, TCW_MODE_CLEAR, 2'h0});
      wr(TCW_ADDR_CMPA, c);
      wr(TCW_ADDR_COUNT, n0);
      wr(TCW_ADDR_FLAGS, 8'h03);
      wr(TCW_ADDR_CTRL, {3'h1, md, act});
      repeat (k) @(posedge clk_i);
   endtask

   // Main sequence.
   initial begin
      logic [31:0] rd;
      void'($urandom(32'h2ad8479b));
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      wb(0, 8'h40, 8'h00, rd);
      check(0, rd);
      wr(TCW_ADDR_PORT, 8'h01);
      wr(TCW_ADDR_CTRL, {3'h0, TCW_MODE_NORMAL, TCW_ACT_SET});
      wr(TCW_ADDR_FORCE, 8'h01);
      wb(0, TCW_ADDR_FLAGS, 8'h00, rd);
      check(32'h4, rd);
      wr(TCW_ADDR_CTRL, {3'h0, TCW_MODE_NORMAL, TCW_ACT_CLEAR});
      wr(TCW_ADDR_FORCE, 8'h01);
      wb(0, TCW_ADDR_FLAGS, 8'h00, rd);
      check(32'h0, rd);
      wr(TCW_ADDR_CTRL, {3'h0, TCW_MODE_NORMAL, TCW_ACT_TOGGLE});
      wr(TCW_ADDR_FORCE, 8'h01);
      wr(TCW_ADDR_PORT, 8'h02);
      run(TCW_MODE_NORMAL, TCW_ACT_TOGGLE, 8'($urandom_range(9, 2)), 8'hf8,
          30);
      wr(TCW_ADDR_CTRL, {3'($urandom_range(7, 2)), TCW_MODE_NORMAL,
         TCW_ACT_TOGGLE});
      repeat (2100) @(posedge clk_i);
      run(TCW_MODE_CLEAR, TCW_ACT_TOGGLE, 8'h00, 8'hff, 12);
      run(TCW_MODE_CLEAR, TCW_ACT_CLEAR, 8'($urandom_range(6, 1)), 8'h00,
          30);
      run(TCW_MODE_CLEAR, TCW_ACT_TOGGLE, 8'h03, 8'h20, 260);
      run(TCW_MODE_FAST_MAX, TCW_ACT_CLEAR, 8'h40, 8'h00, 300);
      wr(TCW_ADDR_CMPA, 8'h80);
      repeat (300) @(posedge clk_i);
      run(TCW_MODE_FAST_MAX, TCW_ACT_SET, 8'h00, 8'h00, 300);
      run(TCW_MODE_FAST_MAX, TCW_ACT_CLEAR, 8'hff, 8'h00, 300);
      run(TCW_MODE_FAST_CMP, TCW_ACT_TOGGLE, 8'h05, 8'h00, 30);
      run(TCW_MODE_FAST_MAX, TCW_ACT_OFF, 8'h10, 8'h00, 300);
      finish_test();
   end
endmodule // tcw_timer_test
